// ===== pkg/power_gate_pkg.sv
// Package for the low-power gating controller: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
package power_gate_pkg;
	localparam logic [7:0] clock_ctrl_addr = 8'h00;
	localparam logic [7:0] module_ctrl_addr = 8'h04;
	localparam logic [7:0] volt_ctrl_addr = 8'h08;
	localparam logic [7:0] flash_ctrl_addr = 8'h0C;
	localparam logic [7:0] status_addr = 8'h10;
	// Clock control fields
	localparam int low_speed_osc_stop_bit = 0;
	localparam int high_speed_osc_enable_bit = 1;
	localparam int wait_periph_clock_stop_bit = 2;
	// Module control fields
	localparam int timer_a_cutoff_bit = 0;
	localparam int timer_b_cutoff_bit = 1;
	localparam int timer_c_standby_bit = 2;
	localparam int timer_d_standby_bit = 3;
	localparam int serial_unit_standby_bit = 4;
	localparam int converter_operate_bit = 5;
	// Voltage control fields
	localparam int volt_detect0_enable_bit = 0;
	localparam int volt_detect1_enable_bit = 1;
	localparam int volt_detect2_enable_bit = 2;
	localparam int internal_power_reduce_bit = 3;
	// Flash control fields
	localparam int flash_stop_bit = 0;
	localparam int low_current_read_enable_bit = 1;
	localparam int erase_suspend_request_bit = 2;
	localparam int cpu_rewrite_enable_bit = 3;
	// Status fields
	localparam int st_wait_bit = 0;
	localparam int st_stop_bit = 1;
	localparam int st_flash_power_bit = 2;
	localparam int st_low_current_bit = 3;
	localparam int st_power_reduce_bit = 4;
	// Reset values: everything running, detectors on, flash bits 0
	localparam logic [2:0] clock_ctrl_rst = 3'h2;
	localparam logic [5:0] module_ctrl_rst = 6'h20;
	localparam logic [3:0] volt_ctrl_rst = 4'h7;
	localparam logic [3:0] flash_ctrl_rst = 4'h0;
	localparam int num_gates = 10;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// ===== hw/clock_gate_cell.sv
// Glitch-free clock gate: enable captured while clock is low.
// Assumes a free-running source clock; enable may change at any time.
`timescale 1ns/1ps
`default_nettype none
module clock_gate_cell (
	input wire logic clk_in, // Source clock
	input wire logic enable, // Gate open when high
	output logic clk_out // Gated clock
);
	logic enable_latched;
	// Latch transparent only on low phase, so the gate moves on a low boundary
	always_latch begin
		if (!clk_in) begin
			enable_latched <= enable;
		end
	end
	assign clk_out = clk_in & enable_latched;
endmodule // clock_gate_cell
`default_nettype wire

// ===== hw/low_power_gating_control.sv
// Low-power gating controller: oscillator, peripheral clock, module standby,
// voltage detector enables and flash power control behind an AXI4-Lite slave.
// Assumes wait/stop requests come from the CPU power controller, synchronous to core_clk.
// How it works
// - Low-current read in low-speed modes when enabled
// - Detector 1 and 2 enables gate circuits
// - Detector 0 enable gates circuit 0
// - GPIO states held during wait and stop
// - Separate bits for both internal oscillators: low-speed stop, high-speed enable
// - Divided peripheral clocks stop in wait
// - Timer A/B count sources cut by bits
// - Timer C standby bit
// - Converter standby when operate bit cleared
// - Serial standby covers sync serial and I2C
// - Flash stop halts flash and blocks access
// - Flash auto power-off in wait/stop, no rewrite
// - Timer D standby bit
// - Internal power reduce in low-speed wait
// - Erase suspend request set suspends, clear resumes
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module low_power_gating_control #(
	parameter int gpio_width = 8
) (
	input wire logic core_clk, // CPU clock
	input wire logic reset, // Synchronous active-high reset
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic wait_mode, // Device is in wait mode
	input wire logic stop_mode, // Device is in stop mode
	input wire logic low_speed_mode, // Low-speed clock or low-speed oscillator mode
	input wire logic [gpio_width-1:0] gpio_out_in, // Programmed GPIO output state
	input wire logic [gpio_width-1:0] gpio_oe_in, // Programmed GPIO enables
	output logic [gpio_width-1:0] gpio_out, // Held GPIO output state
	output logic [gpio_width-1:0] gpio_oe, // Held GPIO enables
	output logic low_speed_osc_run, // Low-speed oscillator enable
	output logic high_speed_osc_run, // High-speed oscillator enable
	output logic periph_clk_f1, // Gated peripheral clock /1
	output logic periph_clk_f2, // Gated peripheral clock /2
	output logic periph_clk_f4, // Gated peripheral clock /4
	output logic periph_clk_f8, // Gated peripheral clock /8
	output logic periph_clk_f32, // Gated peripheral clock /32
	output logic timer_a_clk, // Timer A count source
	output logic timer_b_clk, // Timer B count source
	output logic timer_c_clk, // Timer C module clock
	output logic timer_d_clk, // Timer D module clock
	output logic serial_clk, // Sync serial and I2C module clock
	output logic converter_analog_on, // Converter analog current enable
	output logic volt_detect0_on, // Voltage detection circuit 0 enable
	output logic volt_detect1_on, // Voltage detection circuit 1 enable
	output logic volt_detect2_on, // Voltage detection circuit 2 enable
	output logic internal_power_low, // Internal power reduction active
	output logic flash_power_on, // Flash supply enable
	output logic flash_access_ok, // Flash accesses allowed
	output logic flash_low_current, // Flash low-current read mode
	output logic erase_suspend, // Erase suspend request to flash
	output logic blank_check_block // Blank check command blocked
);
	logic [2:0] clock_ctrl_q, clock_ctrl_d;
	logic [5:0] module_ctrl_q, module_ctrl_d;
	logic [3:0] volt_ctrl_q, volt_ctrl_d;
	logic [3:0] flash_ctrl_q, flash_ctrl_d;
	logic [gpio_width-1:0] gpio_out_q, gpio_oe_q;
	logic [4:0] div_cnt_q;
	logic [4:0] div_en_q;
	logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;

	// Write path: address and data captured independently, then committed together
	wire aw_take = s_axi_awvalid && !aw_held_q && !bvalid_q;
	wire w_take = s_axi_wvalid && !w_held_q && !bvalid_q;
	wire aw_have = aw_held_q || aw_take;
	wire w_have = w_held_q || w_take;
	wire commit = aw_have && w_have && !bvalid_q;
	wire [7:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
	wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
	wire wr_lane0 = commit && wr_strb[0];
	wire wr_clock = wr_lane0 && (wr_addr == power_gate_pkg::clock_ctrl_addr);
	wire wr_module = wr_lane0 && (wr_addr == power_gate_pkg::module_ctrl_addr);
	wire wr_volt = wr_lane0 && (wr_addr == power_gate_pkg::volt_ctrl_addr);
	wire wr_flash = wr_lane0 && (wr_addr == power_gate_pkg::flash_ctrl_addr);
	wire wr_mapped = (wr_addr == power_gate_pkg::clock_ctrl_addr)
		|| (wr_addr == power_gate_pkg::module_ctrl_addr)
		|| (wr_addr == power_gate_pkg::volt_ctrl_addr)
		|| (wr_addr == power_gate_pkg::flash_ctrl_addr)
		|| (wr_addr == power_gate_pkg::status_addr);

	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	assign clock_ctrl_d = wr_clock ? wr_data[2:0] : clock_ctrl_q;
	assign module_ctrl_d = wr_module ? wr_data[5:0] : module_ctrl_q;
	assign volt_ctrl_d = wr_volt ? wr_data[3:0] : volt_ctrl_q;
	assign flash_ctrl_d = wr_flash ? wr_data[3:0] : flash_ctrl_q;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= power_gate_pkg::resp_okay;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			aw_held_q <= aw_have && !commit;
			w_held_q <= w_have && !commit;
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (commit) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? power_gate_pkg::resp_okay : power_gate_pkg::resp_slverr;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Control registers; reset leaves everything running
	always_ff @(posedge core_clk) begin
		if (reset) begin
			clock_ctrl_q <= power_gate_pkg::clock_ctrl_rst;
			module_ctrl_q <= power_gate_pkg::module_ctrl_rst;
			volt_ctrl_q <= power_gate_pkg::volt_ctrl_rst;
			flash_ctrl_q <= power_gate_pkg::flash_ctrl_rst;
		end else begin
			clock_ctrl_q <= clock_ctrl_d;
			module_ctrl_q <= module_ctrl_d;
			volt_ctrl_q <= volt_ctrl_d;
			flash_ctrl_q <= flash_ctrl_d;
		end
	end

	// Read path
	wire sleeping = wait_mode || stop_mode;
	wire rewrite_on = flash_ctrl_q[power_gate_pkg::cpu_rewrite_enable_bit];
	wire [4:0] status_word = {internal_power_low, flash_low_current, flash_power_on,
		stop_mode, wait_mode};
	wire [31:0] rd_word =
		(s_axi_araddr == power_gate_pkg::clock_ctrl_addr) ? {29'h0, clock_ctrl_q} :
		(s_axi_araddr == power_gate_pkg::module_ctrl_addr) ? {26'h0, module_ctrl_q} :
		(s_axi_araddr == power_gate_pkg::volt_ctrl_addr) ? {28'h0, volt_ctrl_q} :
		(s_axi_araddr == power_gate_pkg::flash_ctrl_addr) ? {28'h0, flash_ctrl_q} :
		(s_axi_araddr == power_gate_pkg::status_addr) ? {27'h0, status_word} : 32'h0000_0000;
	wire rd_mapped = (s_axi_araddr == power_gate_pkg::clock_ctrl_addr)
		|| (s_axi_araddr == power_gate_pkg::module_ctrl_addr)
		|| (s_axi_araddr == power_gate_pkg::volt_ctrl_addr)
		|| (s_axi_araddr == power_gate_pkg::flash_ctrl_addr)
		|| (s_axi_araddr == power_gate_pkg::status_addr);
	wire ar_take = s_axi_arvalid && !rvalid_q;

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= power_gate_pkg::resp_okay;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_mapped ? power_gate_pkg::resp_okay : power_gate_pkg::resp_slverr;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Pin states freeze while asleep
	always_ff @(posedge core_clk) begin
		if (reset) begin
			gpio_out_q <= '0;
			gpio_oe_q <= '0;
		end else if (!sleeping) begin
			gpio_out_q <= gpio_out_in;
			gpio_oe_q <= gpio_oe_in;
		end
	end
	assign gpio_out = gpio_out_q;
	assign gpio_oe = gpio_oe_q;

	// Prescaler: bit k of the counter toggles at core_clk / 2^(k+1); one-cycle
	// enables mark the divided rates, and the gate below makes a divided clock
	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_cnt_q <= 5'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 5'h01;
		end
	end

	wire periph_stop = wait_mode && clock_ctrl_q[power_gate_pkg::wait_periph_clock_stop_bit];
	wire [4:0] div_tick = {div_cnt_q == 5'h1F, div_cnt_q[2:0] == 3'h7,
		div_cnt_q[1:0] == 2'h3, div_cnt_q[0], 1'b1};

	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_en_q <= 5'h00;
		end else begin
			div_en_q <= div_tick & {5{!periph_stop}};
		end
	end

	// One gate per controlled clock; enables settle on clock low so no runt pulse
	wire [power_gate_pkg::num_gates-1:0] gate_en = {
		!module_ctrl_q[power_gate_pkg::serial_unit_standby_bit],
		!module_ctrl_q[power_gate_pkg::timer_d_standby_bit],
		!module_ctrl_q[power_gate_pkg::timer_c_standby_bit],
		!module_ctrl_q[power_gate_pkg::timer_b_cutoff_bit],
		!module_ctrl_q[power_gate_pkg::timer_a_cutoff_bit],
		div_en_q};
	logic [power_gate_pkg::num_gates-1:0] gated;
	genvar gi;
	generate
		for (gi = 0; gi < power_gate_pkg::num_gates; gi = gi + 1) begin : g_gate
			clock_gate_cell u_gate (
				.clk_in(core_clk),
				.enable(gate_en[gi]),
				.clk_out(gated[gi])
			);
		end
	endgenerate
	assign {serial_clk, timer_d_clk, timer_c_clk, timer_b_clk, timer_a_clk,
		periph_clk_f32, periph_clk_f8, periph_clk_f4, periph_clk_f2, periph_clk_f1} = gated;

	assign low_speed_osc_run = !clock_ctrl_q[power_gate_pkg::low_speed_osc_stop_bit];
	assign high_speed_osc_run = clock_ctrl_q[power_gate_pkg::high_speed_osc_enable_bit];
	assign converter_analog_on = module_ctrl_q[power_gate_pkg::converter_operate_bit];
	assign volt_detect0_on = volt_ctrl_q[power_gate_pkg::volt_detect0_enable_bit];
	assign volt_detect1_on = volt_ctrl_q[power_gate_pkg::volt_detect1_enable_bit];
	assign volt_detect2_on = volt_ctrl_q[power_gate_pkg::volt_detect2_enable_bit];
	// Only meaningful in wait entered from a low-speed mode
	assign internal_power_low = volt_ctrl_q[power_gate_pkg::internal_power_reduce_bit]
		&& wait_mode && low_speed_mode;

	// Flash power drops in sleep unless rewrite mode needs it; register is untouched
	wire flash_stopped = flash_ctrl_q[power_gate_pkg::flash_stop_bit];
	assign flash_power_on = !flash_stopped && !(sleeping && !rewrite_on);
	assign flash_access_ok = flash_power_on;
	// Divider legality is software's job; hardware only qualifies by mode
	assign flash_low_current = flash_ctrl_q[power_gate_pkg::low_current_read_enable_bit]
		&& low_speed_mode && flash_power_on;
	assign erase_suspend = flash_ctrl_q[power_gate_pkg::erase_suspend_request_bit];
	assign blank_check_block = erase_suspend;
endmodule // low_power_gating_control
`default_nettype wire

// ===== verification/low_power_gating_control_asserts.sv
// Port-level checks for the low-power gating controller.
// Assumes it is bound to low_power_gating_control, all on core_clk.
`timescale 1ns/1ps
`default_nettype none
module low_power_gating_control_asserts #(
	parameter int gpio_width = 8
) (
	input wire logic core_clk, // Clock
	input wire logic reset, // Sync reset
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic s_axi_rvalid, // Read valid
	input wire logic s_axi_rready, // Read ready
	input wire logic wait_mode, // Wait
	input wire logic stop_mode, // Stop
	input wire logic low_speed_mode, // Low-speed mode
	input wire logic [gpio_width-1:0] gpio_out_in, // GPIO programmed
	input wire logic [gpio_width-1:0] gpio_out, // GPIO held
	input wire logic periph_clk_f1, // Peripheral clock
	input wire logic timer_a_clk, // Timer A clock
	input wire logic timer_c_clk, // Timer C clock
	input wire logic internal_power_low, // Power reduce
	input wire logic flash_power_on, // Flash power
	input wire logic flash_access_ok, // Flash access
	input wire logic flash_low_current, // Low-current read
	input wire logic erase_suspend, // Suspend request
	input wire logic blank_check_block // Blank check block
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence r_pending;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	chk_gpio_held: assert property ((wait_mode || stop_mode) |=> $stable(gpio_out))
		else $error("gpio output moved while asleep");
	chk_gpio_tracks: assert property (!(wait_mode || stop_mode) |=> gpio_out == $past(gpio_out_in))
		else $error("gpio output did not follow its input");
	chk_access_power: assert property (flash_access_ok == flash_power_on)
		else $error("flash access allowed without power");
	chk_lowcur_mode: assert property (flash_low_current |-> low_speed_mode && flash_power_on)
		else $error("low-current read outside low-speed mode");
	chk_reduce_wait: assert property (internal_power_low |-> wait_mode && low_speed_mode)
		else $error("power reduction outside low-speed wait");
	chk_blank_suspend: assert property (blank_check_block == erase_suspend)
		else $error("blank check not blocked during suspend");
	// Sampled just before the rising edge, i.e. at the end of the low phase
	chk_gate_low: assert property (!(periph_clk_f1 || timer_a_clk || timer_c_clk))
		else $error("gated clock high in low phase");
	chk_read_answer: assert property (ar_taken |=> s_axi_rvalid)
		else $error("read answer late");
	chk_read_hold: assert property (r_pending |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
endmodule // low_power_gating_control_asserts
`default_nettype wire

// ===== verification/low_power_gating_control_tb.sv
// Self-checking bench for the gating controller: registers over AXI4-Lite,
// gate outputs, sleep behaviour. Assumes power_gate_pkg and the design are compiled first.
`timescale 1ns/1ps
`default_nettype none
module low_power_gating_control_tb;
	localparam int gpio_width = 8;
	logic core_clk = 1'b0, reset = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic wait_mode = 1'b0, stop_mode = 1'b0, low_speed_mode = 1'b0;
	logic [7:0] gpio_out_in = 8'h00, gpio_oe_in = 8'h00, gpio_out, gpio_oe, gd, c1, c2, c4, c8, c32;
	logic low_speed_osc_run, high_speed_osc_run, periph_clk_f1, periph_clk_f2, periph_clk_f4;
	logic periph_clk_f8, periph_clk_f32, timer_a_clk, timer_b_clk, timer_c_clk, timer_d_clk;
	logic serial_clk, converter_analog_on, volt_detect0_on, volt_detect1_on, volt_detect2_on;
	logic internal_power_low, flash_power_on, flash_access_ok, flash_low_current;
	logic erase_suspend, blank_check_block, fp;
	int err_count = 0, n_tests = 0;
	always #2 core_clk = ~core_clk;
	low_power_gating_control #(.gpio_width(gpio_width)) u_dut (.core_clk, .reset, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wait_mode, .stop_mode,
		.low_speed_mode, .gpio_out_in, .gpio_oe_in, .gpio_out, .gpio_oe, .low_speed_osc_run,
		.high_speed_osc_run, .periph_clk_f1, .periph_clk_f2, .periph_clk_f4, .periph_clk_f8,
		.periph_clk_f32, .timer_a_clk, .timer_b_clk, .timer_c_clk, .timer_d_clk, .serial_clk,
		.converter_analog_on, .volt_detect0_on, .volt_detect1_on, .volt_detect2_on,
		.internal_power_low, .flash_power_on, .flash_access_ok, .flash_low_current,
		.erase_suspend, .blank_check_block);
	task automatic end_of_test;
		if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Handshakes are sampled at the falling edge, where outputs are settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic a_ok, w_ok;
		a_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge core_clk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(negedge core_clk);
			a_ok = a_ok | s_axi_awready;
			w_ok = w_ok | s_axi_wready;
			@(posedge core_clk);
			if (a_ok) s_axi_awvalid <= 1'b0;
			if (w_ok) s_axi_wvalid <= 1'b0;
		end while (!(a_ok && w_ok));
		do @(negedge core_clk); while (s_axi_bvalid !== 1'b1);
		cmp("bresp", er, s_axi_bresp);
		@(posedge core_clk);
		s_axi_bready <= 1'b0;
	endtask
	// Ready is raised a cycle late so the slave must hold its answer
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(negedge core_clk); while (s_axi_arready !== 1'b1);
		@(posedge core_clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge core_clk); while (s_axi_rvalid !== 1'b1);
		@(posedge core_clk);
		s_axi_rready <= 1'b1;
		@(negedge core_clk);
		cmp("rdata", e, s_axi_rdata);
		cmp("rresp", er, s_axi_rresp);
		@(posedge core_clk);
		s_axi_rready <= 1'b0;
	endtask
	task automatic hi;
		@(posedge core_clk);
		#1;
	endtask
	function automatic logic [5:0] exp_mod(input logic [31:0] m);
		return {~m[4:0], m[5]};
	endfunction
	initial begin
		v = $urandom(28007);
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		rd(8'h00, 32'h2, 2'h0);
		rd(8'h04, 32'h20, 2'h0);
		rd(8'h08, 32'h7, 2'h0);
		rd(8'h0C, 32'h0, 2'h0);
		hi();
		cmp("reset run", {low_speed_osc_run, high_speed_osc_run, volt_detect0_on, volt_detect1_on,
			volt_detect2_on, flash_power_on, flash_low_current}, 7'h7E);
		cmp("reset gates", {serial_clk, timer_d_clk, timer_c_clk, timer_b_clk, timer_a_clk,
			converter_analog_on}, 6'h3F);
		rd(8'h14, 32'h0, 2'h2);
		wr(8'h20, 32'hFFFF_FFFF, 2'h2);
		for (int i = 0; i < 10; i++) begin
			v = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $urandom();
			wr(8'h00, v, 2'h0);
			wr(8'h04, v, 2'h0);
			wr(8'h08, v, 2'h0);
			rd(8'h00, v & 32'h7, 2'h0);
			rd(8'h04, v & 32'h3F, 2'h0);
			rd(8'h08, v & 32'hF, 2'h0);
			hi();
			cmp("oscillators", {low_speed_osc_run, high_speed_osc_run}, {~v[0], v[1]});
			cmp("detectors", {volt_detect2_on, volt_detect1_on, volt_detect0_on}, v[2:0]);
			cmp("module gates", {serial_clk, timer_d_clk, timer_c_clk, timer_b_clk, timer_a_clk,
				converter_analog_on}, exp_mod(v));
		end
		wr(8'h08, 32'hF, 2'h0);
		// The bench acts as RAM-resident code at a legal low-speed divider
		for (int k = 0; k < 48; k++) begin
			// Low-current read and erase suspend are never combined with sleep
			if (k[5:4] != 2'h0 && k[2:1] != 2'h0) continue;
			wr(8'h0C, 32'(k[3:0]), 2'h0);
			{stop_mode, wait_mode} <= k[5:4];
			low_speed_mode <= 1'($urandom());
			hi();
			fp = !k[0] && !(k[5:4] != 2'h0 && !k[3]);
			cmp("flash power", {flash_power_on, flash_access_ok}, {fp, fp});
			cmp("low current", flash_low_current, k[1] & low_speed_mode & fp);
			cmp("suspend", {erase_suspend, blank_check_block}, {k[2], k[2]});
			cmp("reduce", internal_power_low, k[4] & low_speed_mode);
			rd(8'h10, {k[4] & low_speed_mode, k[1] & low_speed_mode & fp, fp, k[5:4]}, 2'h0);
			rd(8'h0C, 32'(k[3:0]), 2'h0);
			{stop_mode, wait_mode} <= 2'h0;
		end
		for (int k = 0; k < 3; k++) begin
			wr(8'h00, (k > 0) ? 32'h6 : 32'h2, 2'h0);
			wait_mode <= (k == 1);
			repeat (2) @(posedge core_clk);
			{c1, c2, c4, c8, c32} = '0;
			repeat (32) begin
				hi();
				{c1, c2, c4, c8, c32} = {c1 + periph_clk_f1, c2 + periph_clk_f2,
					c4 + periph_clk_f4, c8 + periph_clk_f8, c32 + periph_clk_f32};
			end
			cmp("periph counts", {c1, c2, c4, c8, c32}, (k == 1) ? 40'h0 : 40'h20_10_08_04_01);
			@(posedge core_clk);
			wait_mode <= 1'b0;
		end
		// A write without lane 0 must leave the register alone
		s_axi_wstrb <= 4'hE;
		wr(8'h00, 32'h0, 2'h0);
		s_axi_wstrb <= 4'hF;
		rd(8'h00, 32'h6, 2'h0);
		gd = 8'($urandom());
		// Pins settle several cycles before sleep, as software parks them
		{gpio_out_in, gpio_oe_in} <= {gd, ~gd};
		repeat (3) @(posedge core_clk);
		stop_mode <= 1'b1;
		@(posedge core_clk);
		{gpio_out_in, gpio_oe_in} <= {~gd, gd};
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		cmp("gpio held", {gpio_out, gpio_oe}, {gd, ~gd});
		@(posedge core_clk);
		stop_mode <= 1'b0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		cmp("gpio follow", {gpio_out, gpio_oe}, {~gd, gd});
		end_of_test();
	end
	initial begin
		repeat (40000) @(posedge core_clk);
		err_count++;
		end_of_test();
	end
endmodule // low_power_gating_control_tb
bind low_power_gating_control low_power_gating_control_asserts #(.gpio_width(gpio_width)) u_chk (
	.core_clk, .reset, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.wait_mode, .stop_mode, .low_speed_mode, .gpio_out_in, .gpio_out, .periph_clk_f1,
	.timer_a_clk, .timer_c_clk, .internal_power_low, .flash_power_on, .flash_access_ok,
	.flash_low_current, .erase_suspend, .blank_check_block);
`default_nettype wire
